// file: rtl/cte_top.sv
// Charge time edge control unit with classic Wishbone register access
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`include "cte_defs.svh"
module cte_top
    import cte_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic unit_clock_disable,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    input wire logic edge_pin_one,
    input wire logic edge_pin_two,
    input wire logic enhanced_capture_unit,
    input wire logic second_capture_unit,
    input wire logic comp_trip,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic source_on,
    output logic source_ground,
    output logic [1:0] current_range,
    output logic [5:0] current_trim,
    output logic event_trigger,
    output logic pulse_out_pin,
    output logic unit_irq_flag
);
    // ----------------------------------------
    // Clock gating
    // ----------------------------------------
    // Modelled as a clock enable: a gated clock cell is not portable here
    logic gate_r;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            gate_r <= 1'b1;
        end
        else
        begin
            gate_r <= ~unit_clock_disable;
        end
    end
    wire logic clk_en = gate_r;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic pin1_s, pin2_s, cap1_s, cap2_s, trip_s;
    cte_sync u_s1 (.clk(clk), .rst(rst), .d(edge_pin_one), .q(pin1_s));
    cte_sync u_s2 (.clk(clk), .rst(rst), .d(edge_pin_two), .q(pin2_s));
    cte_sync u_s3 (.clk(clk), .rst(rst), .d(enhanced_capture_unit), .q(cap1_s));
    cte_sync u_s4 (.clk(clk), .rst(rst), .d(second_capture_unit), .q(cap2_s));
    cte_sync u_s5 (.clk(clk), .rst(rst), .d(comp_trip), .q(trip_s));

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] main_r;
    logic [7:0] src_r;
    logic [7:0] cur_r;
    logic irq_r;

    wire logic unit_enable = main_r[`CTE_MAIN_EN];
    wire logic stop_in_idle = main_r[`CTE_MAIN_SIDL];
    wire logic delay_gen_enable = main_r[`CTE_MAIN_DELAY_GEN_ENABLE];
    wire logic edge_pass_enable = main_r[`CTE_MAIN_EDGE_PASS_ENABLE];
    wire logic edge_order_enable = main_r[`CTE_MAIN_SEQ];
    wire logic source_discharge = main_r[`CTE_MAIN_DIS];
    wire logic event_trigger_enable = main_r[`CTE_MAIN_TRIG];
    wire logic edge_two_polarity = src_r[`CTE_SRC_POL2];
    wire logic [1:0] edge_two_source = src_r[`CTE_SRC_SEL2_HI:`CTE_SRC_SEL2_LO];
    wire logic edge_one_polarity = src_r[`CTE_SRC_POL1];
    wire logic [1:0] edge_one_source = src_r[`CTE_SRC_SEL1_HI:`CTE_SRC_SEL1_LO];
    wire logic edge_two_seen = src_r[`CTE_SRC_STAT2];
    wire logic edge_one_seen = src_r[`CTE_SRC_STAT1];

    // Unit runs when enabled, clocked, and not halted by Idle
    wire logic halted = idle_mode & stop_in_idle;
    wire logic run = unit_enable & clk_en & ~halted;
    wire logic edge_run = run & edge_pass_enable;

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    // Source index follows the field code: 11 pin one, 10 pin two, 01, 00 capture
    wire logic [3:0] srcs = {pin1_s, pin2_s, cap1_s, cap2_s};
    logic hit1, hit2;

    cte_edge_det u_e1
    (
        .clk(clk),
        .rst(rst),
        .run(edge_run),
        .srcs(srcs),
        .sel(edge_one_source),
        .pol(edge_one_polarity),
        .hit(hit1)
    );

    cte_edge_det u_e2
    (
        .clk(clk),
        .rst(rst),
        .run(edge_run),
        .srcs(srcs),
        .sel(edge_two_source),
        .pol(edge_two_polarity),
        .hit(hit2)
    );

    // Edge two is held off until edge one is seen when ordering is on
    wire logic hit2_ok = hit2 & (~edge_order_enable | edge_one_seen | hit1);

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    // Address decode shared by every register select
    function automatic logic cte_at(input logic [3:0] adr, input logic [3:0] base);
        cte_at = adr == base;
    endfunction

    wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Writes land at the edge where the master samples ack, not one edge earlier
    wire logic commit = wb_cyc_i & wb_stb_i & wb_ack_o;
    wire logic wr_lane0 = commit & wb_we_i & wb_sel_i[0];
    wire logic hit_main = cte_at(wb_adr_i, `CTE_ADDR_MAIN);
    wire logic hit_src = cte_at(wb_adr_i, `CTE_ADDR_SRC);
    wire logic hit_cur = cte_at(wb_adr_i, `CTE_ADDR_CUR);
    wire logic hit_stat = cte_at(wb_adr_i, `CTE_ADDR_STAT);
    wire logic wr_main = wr_lane0 & hit_main;
    wire logic wr_src = wr_lane0 & hit_src;
    wire logic wr_cur = wr_lane0 & hit_cur;
    wire logic wr_stat = wr_lane0 & hit_stat;

    // Status bits: hardware set beats a same-cycle software clear
    wire logic [7:0] src_wr = wr_src ? wb_dat_i[7:0] : src_r;
    wire logic stat1_nxt = src_wr[`CTE_SRC_STAT1] | hit1;
    wire logic stat2_nxt = src_wr[`CTE_SRC_STAT2] | hit2_ok;
    wire logic [7:0] src_nxt = {src_wr[7:2], stat2_nxt, stat1_nxt};

    // Sequence is complete when both edges are seen for the first time
    wire logic seq_done = stat1_nxt & stat2_nxt & ~(edge_one_seen & edge_two_seen);
    wire logic irq_nxt = (irq_r & ~(wr_stat & wb_dat_i[0])) | (run & seq_done);

    wire logic [7:0] rd_byte =
        hit_main ? (main_r & `CTE_MAIN_MASK) :
        hit_src ? src_r :
        hit_cur ? cur_r :
        hit_stat ? {7'h00, irq_r} : 8'h00;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Each register has its own short process; any reset clears all of them
    wire logic [7:0] main_nxt = wr_main ? (wb_dat_i[7:0] & `CTE_MAIN_MASK) : main_r;
    wire logic [7:0] cur_nxt = wr_cur ? wb_dat_i[7:0] : cur_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            main_r <= `CTE_REG_RESET;
        end
        else
        begin
            main_r <= main_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cur_r <= `CTE_REG_RESET;
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    // Clearing the status bits drops a measurement cut short by reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            src_r <= `CTE_REG_RESET;
        end
        else
        begin
            src_r <= src_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_r <= 1'h0;
        end
        else
        begin
            irq_r <= irq_nxt;
        end
    end

    // ----------------------------------------
    // Delay pulse generation
    // ----------------------------------------
    cte_pulse_t pstate_r, pstate_nxt;
    always_comb
    begin
        pstate_nxt = pstate_r;
        case (pstate_r)
            CTE_PULSE_IDLE:
                if (run & delay_gen_enable & edge_one_seen & ~trip_s)
                begin
                    pstate_nxt = CTE_PULSE_ARMED;
                end
            CTE_PULSE_ARMED:
                if (~run | ~delay_gen_enable)
                begin
                    pstate_nxt = CTE_PULSE_IDLE;
                end
                else if (trip_s)
                begin
                    pstate_nxt = CTE_PULSE_DONE;
                end
            CTE_PULSE_DONE:
                // Rearm only after status bit one clears or delay generation is disabled, one pulse per charge
                if (~edge_one_seen | ~delay_gen_enable)
                begin
                    pstate_nxt = CTE_PULSE_IDLE;
                end
            default:
                pstate_nxt = CTE_PULSE_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pstate_r <= CTE_PULSE_IDLE;
        end
        else
        begin
            pstate_r <= pstate_nxt;
        end
    end

    // ----------------------------------------
    // Analog control outputs
    // ----------------------------------------
    // Drive while exactly one status bit is set
    wire logic charge = edge_one_seen ^ edge_two_seen;
    wire logic range_on = cur_r[`CTE_CUR_RNG_HI:`CTE_CUR_RNG_LO] != CTE_RNG_OFF;
    wire logic src_on_nxt = run & ~sleep_mode & range_on & charge;
    wire logic ground_nxt = unit_enable & source_discharge;
    wire logic trig_nxt = run & event_trigger_enable & seq_done;
    // One pulse on the step from armed to done, so a held trip cannot repeat it
    wire logic pulse_nxt = (pstate_r == CTE_PULSE_ARMED) & trip_s
        & delay_gen_enable & run;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            source_on <= 1'h0;
            source_ground <= 1'h0;
        end
        else
        begin
            source_on <= src_on_nxt;
            source_ground <= ground_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            current_range <= 2'h0;
            current_trim <= 6'h00;
        end
        else
        begin
            current_range <= cur_r[`CTE_CUR_RNG_HI:`CTE_CUR_RNG_LO];
            current_trim <= cur_r[`CTE_CUR_TRIM_HI:`CTE_CUR_TRIM_LO];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            event_trigger <= 1'h0;
            pulse_out_pin <= 1'h0;
            unit_irq_flag <= 1'h0;
        end
        else
        begin
            event_trigger <= trig_nxt;
            pulse_out_pin <= pulse_nxt;
            unit_irq_flag <= irq_nxt;
        end
    end
endmodule

// file: rtl/cte_defs.svh
// Register offsets, field positions and reset values of the edge control unit
`ifndef CTE_DEFS_SVH
`define CTE_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CTE_ADDR_MAIN 4'h0
`define CTE_ADDR_SRC 4'h4
`define CTE_ADDR_CUR 4'h8
`define CTE_ADDR_STAT 4'hc

// ----------------------------------------
// Main control fields
// ----------------------------------------
`define CTE_MAIN_EN 7
`define CTE_MAIN_SIDL 5
`define CTE_MAIN_DELAY_GEN_ENABLE 4
`define CTE_MAIN_EDGE_PASS_ENABLE 3
`define CTE_MAIN_SEQ 2
`define CTE_MAIN_DIS 1
`define CTE_MAIN_TRIG 0
`define CTE_MAIN_MASK 8'hbf

// ----------------------------------------
// Edge source control fields
// ----------------------------------------
`define CTE_SRC_POL2 7
`define CTE_SRC_SEL2_HI 6
`define CTE_SRC_SEL2_LO 5
`define CTE_SRC_POL1 4
`define CTE_SRC_SEL1_HI 3
`define CTE_SRC_SEL1_LO 2
`define CTE_SRC_STAT2 1
`define CTE_SRC_STAT1 0

// ----------------------------------------
// Current control fields and reset value
// ----------------------------------------
`define CTE_CUR_TRIM_HI 7
`define CTE_CUR_TRIM_LO 2
`define CTE_CUR_RNG_HI 1
`define CTE_CUR_RNG_LO 0
`define CTE_REG_RESET 8'h00

`endif

// file: rtl/cte_pkg.sv
// Types shared by the edge control unit files
package cte_pkg;

    typedef enum logic [1:0]
    {
        CTE_SRC_CAPTURE2 = 2'b00,
        CTE_SRC_CAPTURE1 = 2'b01,
        CTE_SRC_PIN2 = 2'b10,
        CTE_SRC_PIN1 = 2'b11
    } cte_src_t;

    typedef enum logic [1:0]
    {
        CTE_RNG_OFF = 2'b00,
        CTE_RNG_BASE = 2'b01,
        CTE_RNG_X10 = 2'b10,
        CTE_RNG_X100 = 2'b11
    } cte_range_t;

    typedef enum logic [1:0]
    {
        CTE_PULSE_IDLE = 2'b00,
        CTE_PULSE_ARMED = 2'b01,
        CTE_PULSE_DONE = 2'b10
    } cte_pulse_t;

endpackage

// file: rtl/cte_sync.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module cte_sync
(
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// file: rtl/cte_edge_det.sv
// Source select and polarity edge detector for one edge channel
`timescale 1ns/1ns
module cte_edge_det
    import cte_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [3:0] srcs,
    input wire logic [1:0] sel,
    input wire logic pol,
    output logic hit
);
    logic prev_r;
    wire logic lvl = srcs[sel];

    // Previous level is tracked while halted so no false edge on wake-up
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev_r <= 1'b0;
        end
        else
        begin
            prev_r <= lvl;
        end
    end

    assign hit = run & (pol ? (lvl & ~prev_r) : (~lvl & prev_r));
endmodule

// file: tb/cte_far_side.sv
// Far side model: edge sources and a charging capacitor behind a comparator
`timescale 1ns/1ns
module cte_far_side
#(
    parameter int CHARGE = 6
)
(
    input wire logic clk,
    input wire logic [3:0] lvl,
    input wire logic source_on,
    input wire logic source_ground,
    output logic [3:0] srcs,
    output logic comp_trip
);
    int cap = 0;
    initial
    begin
        srcs = 4'h0;
        comp_trip = 1'b0;
    end
    // Charge is kept until grounded, so a stale trip must be drained first
    always @(posedge clk)
    begin
        srcs <= lvl;
        if (source_ground)
            cap <= 0;
        else if (source_on && cap < CHARGE)
            cap <= cap + 1;
        comp_trip <= cap >= CHARGE;
    end
endmodule

// file: tb/cte_top_assertions.sv
// Port assertions and covers for the charge time edge control unit
`timescale 1ns/1ns
module cte_top_assertions
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sleep_mode,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic source_on,
    input wire logic source_ground,
    input wire logic [1:0] current_range,
    input wire logic event_trigger,
    input wire logic pulse_out_pin,
    input wire logic unit_irq_flag
);
    logic [3:0] adr_r;
    logic we_r;
    wire rd_main = wb_ack_o && adr_r == 4'h0 && !we_r;
    wire rd_flag = wb_ack_o && adr_r == 4'hc && !we_r;
    always_ff @(posedge clk)
    begin
        adr_r <= wb_adr_i;
        we_r <= wb_we_i;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_reset_clears: assert property (disable iff (1'b0) rst |=>
        !source_on && !source_ground && !unit_irq_flag && !wb_ack_o)
        else $error("outputs not cleared by reset");
    a_sleep_off: assert property (sleep_mode |=> !source_on)
        else $error("source on in sleep");
    a_pulse_once: assert property (pulse_out_pin |=> !pulse_out_pin)
        else $error("pulse too long");
    a_trig_once: assert property (event_trigger |=> !event_trigger)
        else $error("trigger too long");
    a_gap_zero: assert property (rd_main |-> !wb_dat_o[6])
        else $error("gap bit set");
    a_ground_track: assert property (
        rd_main |-> source_ground == (wb_dat_o[7] && wb_dat_o[1]))
        else $error("ground mismatch");
    a_range_off: assert property (
        current_range == 2'b00 && $past(current_range) == 2'b00 |-> !source_on)
        else $error("source on with range off");
    a_flag_read: assert property (rd_flag |-> wb_dat_o[0] == $past(unit_irq_flag))
        else $error("flag mismatch");
    c_pulse: cover property (pulse_out_pin);
    c_trig: cover property (event_trigger);
    c_source: cover property (source_on);
endmodule
bind cte_top cte_top_assertions i_cte_top_assertions
(
    .clk, .rst, .sleep_mode, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .source_on,
    .source_ground, .current_range, .event_trigger, .pulse_out_pin, .unit_irq_flag
);

// file: tb/test_charge_time_edge_control.sv
// Self-checking bench for the charge time edge control unit
`timescale 1ns/1ns
module test_charge_time_edge_control;
    logic clk = 1'b0, rst = 1'b1, req = 1'b0, wb_we_i = 1'b0;
    logic unit_clock_disable = 1'b0, idle_mode = 1'b0, sleep_mode = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, lvl = 4'h0, srcs;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic [1:0] current_range;
    logic [5:0] current_trim;
    logic wb_ack_o, source_on, source_ground, event_trigger, pulse_out_pin;
    logic unit_irq_flag, comp_trip;
    logic [7:0] m [4];
    logic [7:0] blk [4] = '{8'h80, 8'h88, 8'ha8, 8'h08};
    int num_errors = 0, checked = 0, cycles = 0, pulses = 0, trigs = 0, t0;
    cte_top i_cte_top
    (
        .clk, .rst, .unit_clock_disable, .idle_mode, .sleep_mode,
        .edge_pin_one(srcs[3]), .edge_pin_two(srcs[2]), .enhanced_capture_unit(srcs[1]),
        .second_capture_unit(srcs[0]), .comp_trip, .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i, .wb_adr_i, .wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .source_on, .source_ground, .current_range, .current_trim, .event_trigger,
        .pulse_out_pin, .unit_irq_flag
    );
    cte_far_side i_cte_far_side
    (
        .clk, .lvl, .source_on, .source_ground, .srcs, .comp_trip
    );
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        pulses += int'(pulse_out_pin === 1'b1);
        trigs += int'(event_trigger === 1'b1);
        if (cycles == 5000)
        begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Holds the request until ack is sampled, then leaves one idle cycle
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] dv);
        req <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, dv};
        do
            @(posedge clk);
        while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] dv);
        bus(1'b1, a, dv);
        if (a == 4'hc)
            m[3] = m[3] & ~dv;
        else
            m[a[3:2]] = (a == 4'h0) ? (dv & 8'hbf) : dv;
    endtask
    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 8'h00);
        chk("register", rdat, {24'h0, m[a[3:2]]});
    endtask
    task automatic finish_test();
        $display("Comparisons %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial
    begin
        void'($urandom(27227));
        m = '{default: 8'h00};
        tick(2);
        rst <= 1'b0;
        tick(1);
        for (int i = 0; i < 4; i++)
            rd(4'(4 * i));
        bus(1'b0, 4'h2, 8'h00);
        chk("hole", rdat, 32'h0);
        for (int i = 0; i < 12; i++)
        begin
            wr(4'h0, 8'($urandom));
            wr(4'h4, 8'($urandom) & 8'hfd);
            wr(4'h8, 8'($urandom));
            for (int r = 0; r < 3; r++)
                rd(4'(4 * r));
            chk("range", current_range, m[2][1:0]);
            chk("trim", current_trim, m[2][7:2]);
            chk("ground", source_ground, m[0][7] & m[0][1]);
            chk("source", source_on, m[0][7] & (|m[2][1:0]) & m[1][0]);
        end
        wr(4'h0, 8'h82);
        wr(4'h4, 8'hdc);
        wr(4'h0, 8'h8d);
        t0 = trigs;
        lvl[2] <= 1'b1;
        tick(6);
        rd(4'h4);
        lvl[3] <= 1'b1;
        tick(6);
        m[1][0] = 1'b1;
        rd(4'h4);
        lvl[2] <= 1'b0;
        tick(6);
        lvl[2] <= 1'b1;
        tick(6);
        m[1][1] = 1'b1;
        m[3] = 8'h01;
        rd(4'h4);
        chk("trigger", trigs - t0, 1);
        rd(4'hc);
        wr(4'hc, 8'h01);
        rd(4'hc);
        lvl <= 4'h0;
        wr(4'h0, 8'h88);
        for (int s = 0; s < 4; s++)
        begin
            wr(4'h4, {1'b0, 2'(s), 1'b0, 2'(s), 2'b00});
            lvl[s] <= 1'b1;
            tick(6);
            rd(4'h4);
            lvl[s] <= 1'b0;
            tick(6);
            m[1][1:0] = 2'b11;
            rd(4'h4);
        end
        for (int k = 0; k < 4; k++)
        begin
            unit_clock_disable <= (k == 1);
            idle_mode <= (k == 2);
            wr(4'h0, blk[k]);
            wr(4'h4, 8'h1c);
            lvl[3] <= 1'b1;
            tick(6);
            rd(4'h4);
            lvl[3] <= 1'b0;
            tick(6);
        end
        unit_clock_disable <= 1'b0;
        // Idle without stop-in-idle must leave the unit running
        idle_mode <= 1'b1;
        wr(4'h0, 8'h82);
        tick(4);
        wr(4'h0, 8'h98);
        wr(4'h8, 8'h01);
        t0 = pulses;
        wr(4'h4, 8'h01);
        tick(30);
        chk("pulse", pulses - t0, 1);
        chk("source", source_on, 1);
        sleep_mode <= 1'b1;
        tick(2);
        chk("sleep", source_on, 0);
        sleep_mode <= 1'b0;
        tick(2);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        m = '{default: 8'h00};
        tick(1);
        chk("reset", source_on, 0);
        rd(4'h4);
        finish_test();
    end
endmodule
